// file: logic/rlp_pkg.sv
package rlp_pkg;

    localparam int unsigned NUM_GROUPS      = 3;
    localparam int unsigned CH_PER_GROUP    = 8;
    localparam int unsigned NUM_CH          = NUM_GROUPS * CH_PER_GROUP;
    localparam int unsigned CC_SPLIT_CH     = 6;

    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_RED_PERIOD   = 8'h00;
    localparam logic [7:0] IDX_GREEN_CUR    = 8'h01;
    localparam logic [7:0] IDX_BLUE_CUR     = 8'h02;
    localparam logic [7:0] IDX_DUTY_BASE    = 8'h10;
    localparam logic [7:0] IDX_IRQ_STATUS   = 8'h30;
    localparam logic [7:0] IDX_IRQ_MASK     = 8'h31;
    localparam logic [7:0] IDX_LIVE_STATE   = 8'h32;

    localparam int unsigned PERIOD_SEL_LSB  = 5;
    localparam int unsigned CUR_CODE_LSB    = 0;
    localparam logic [7:0]  REG_RESET       = 8'h00;

    // Interrupt status and mask bit positions
    localparam int unsigned EV_THERM_OFF    = 0;
    localparam int unsigned EV_THERM_ON     = 1;
    localparam int unsigned EV_UVLO         = 2;
    localparam int unsigned EV_PERIOD       = 3;
    localparam int unsigned NUM_EV          = 4;

    // Live state bit positions
    localparam int unsigned LS_THERM        = 0;
    localparam int unsigned LS_UVLO         = 1;
    localparam int unsigned LS_SPLIT_LSB    = 2;

    // Three-level split select encoding
    localparam logic [1:0] SPLIT_LOW        = 2'h0;
    localparam logic [1:0] SPLIT_MID        = 2'h1;
    localparam logic [1:0] SPLIT_HIGH       = 2'h2;

    localparam logic [2:0] PERIOD_MAX_CODE  = 3'h4;

    // PWM time base
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned BASE_PERIOD_NS  = 500000;
    localparam int unsigned PWM_STEPS       = 256;
    localparam int unsigned BASE_TICK_CYCLES =
        BASE_PERIOD_NS / (PWM_STEPS * CLK_PERIOD_NS);

    typedef enum logic [0:0] {
        RLP_SCAN_IDLE,
        RLP_SCAN_RUN
    } rlp_scan_state_t;

    // Current fraction in percent for a group current code
    function automatic logic [6:0] rlp_cur_pct(input logic [2:0] code);
        logic [6:0] pct;
        pct = 7'h00;
        case (code)
            3'h0: pct = 7'd20;
            3'h1: pct = 7'd31;
            3'h2: pct = 7'd43;
            3'h3: pct = 7'd54;
            3'h4: pct = 7'd66;
            3'h5: pct = 7'd77;
            3'h6: pct = 7'd88;
            default: pct = 7'd100;
        endcase
        return pct;
    endfunction : rlp_cur_pct

endpackage : rlp_pkg

// file: logic/rlp_duty_if.sv
`timescale 1ns/100ps
interface rlp_duty_if #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned AW    = 5
);
    logic             wr_en;
    logic [AW-1:0]    wr_addr;
    logic [WIDTH-1:0] wr_data;
    logic [AW-1:0]    bus_addr;
    logic [WIDTH-1:0] bus_data;
    logic [AW-1:0]    scan_addr;
    logic [WIDTH-1:0] scan_data;

    modport ctrl (output wr_en, wr_addr, wr_data, bus_addr, scan_addr,
                  input  bus_data, scan_data);
    modport mem  (input  wr_en, wr_addr, wr_data, bus_addr, scan_addr,
                  output bus_data, scan_data);
endinterface : rlp_duty_if

// file: logic/rlp_duty_mem.sv
`timescale 1ns/100ps
module rlp_duty_mem #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 24,
    parameter int unsigned AW    = 5
) (
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    rlp_duty_if.mem    port
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] bus_q;
    logic [WIDTH-1:0] scan_q;

    // Reset clears every duty so all channels start off
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_q[i] <= '0;
            end
        end
        else if (port.wr_en && (32'(port.wr_addr) < DEPTH))
        begin
            mem_q[port.wr_addr] <= port.wr_data;
        end
    end

    // Out-of-range addresses read as zero
    always_ff @(posedge clk_i)
    begin
        bus_q  <= (32'(port.bus_addr) < DEPTH) ? mem_q[port.bus_addr] : '0;
        scan_q <= (32'(port.scan_addr) < DEPTH) ? mem_q[port.scan_addr] : '0;
    end

    assign port.bus_data  = bus_q;
    assign port.scan_data = scan_q;
endmodule : rlp_duty_mem

// file: logic/rlp_pwm_core.sv
`timescale 1ns/100ps
module rlp_pwm_core
    import rlp_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = BASE_TICK_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    input  wire logic        uvlo_i,
    input  wire logic        overtemp_i,
    input  wire logic        temp_resume_i,
    input  wire logic [1:0]  output_split_select_i,
    output logic      [7:0]  red_channel_out_o,
    output logic      [7:0]  green_channel_out_o,
    output logic      [7:0]  blue_channel_out_o,
    output logic      [7:0]  open_drain_mode_o,
    output logic      [2:0]  red_group_current_code_o,
    output logic      [2:0]  green_group_current_code_o,
    output logic      [2:0]  blue_group_current_code_o,
    output logic      [6:0]  red_current_pct_o,
    output logic      [6:0]  green_current_pct_o,
    output logic      [6:0]  blue_current_pct_o
);
    localparam int unsigned AW = 5;

    rlp_duty_if #(.WIDTH(8), .AW(AW)) duty ();

    rlp_duty_mem #(.WIDTH(8), .DEPTH(NUM_CH), .AW(AW)) u_duty_mem (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .port  (duty.mem)
    );

    // Setting registers and interrupt status
    logic [7:0]        red_period_q;
    logic [7:0]        green_cur_q;
    logic [7:0]        blue_cur_q;
    logic [NUM_EV-1:0] irq_status_q;
    logic [NUM_EV-1:0] irq_mask_q;

    // Pin synchronisers: three stages, change accepted when 2 and 3 agree
    logic [4:0] pin_raw;
    logic [4:0] pin_s1_q;
    logic [4:0] pin_s2_q;
    logic [4:0] pin_s3_q;
    logic [4:0] pin_q;

    assign pin_raw = {output_split_select_i, temp_resume_i, overtemp_i, uvlo_i};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
        end
        else
        begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    genvar gp;
    generate
        for (gp = 0; gp < 5; gp++)
        begin : g_pin
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    pin_q[gp] <= 1'b0;
                else if (pin_s2_q[gp] == pin_s3_q[gp])
                    pin_q[gp] <= pin_s3_q[gp];
            end
        end
    endgenerate

    wire       uvlo_w      = pin_q[0];
    wire       hot_w       = pin_q[1];
    wire       cool_w      = pin_q[2];
    wire [1:0] split_w     = pin_q[4:3];

    // Thermal shutdown holds from the hot indication until the cool one
    logic therm_off_q;
    logic uvlo_prev_q;
    wire  therm_set   = hot_w && !therm_off_q;
    wire  therm_clear = therm_off_q && cool_w && !hot_w;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            therm_off_q <= 1'b0;
        else if (therm_set)
            therm_off_q <= 1'b1;
        else if (therm_clear)
            therm_off_q <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            uvlo_prev_q <= 1'b0;
        else
            uvlo_prev_q <= uvlo_w;
    end

    // Wishbone decode
    wire        req       = wb_cyc_i && wb_stb_i;
    wire [7:0]  idx       = wb_adr_i[9:2];
    wire        upper_nz  = |wb_adr_i[31:10];
    wire        hit_rp    = !upper_nz && idx == IDX_RED_PERIOD;
    wire        hit_g     = !upper_nz && idx == IDX_GREEN_CUR;
    wire        hit_b     = !upper_nz && idx == IDX_BLUE_CUR;
    wire        hit_duty  = !upper_nz && idx >= IDX_DUTY_BASE
                            && idx < IDX_DUTY_BASE + 8'(NUM_CH);
    wire        hit_st    = !upper_nz && idx == IDX_IRQ_STATUS;
    wire        hit_mask  = !upper_nz && idx == IDX_IRQ_MASK;
    wire        hit_live  = !upper_nz && idx == IDX_LIVE_STATE;
    wire [7:0]  duty_off  = idx - IDX_DUTY_BASE;

    logic pend_q;
    logic ack_q;
    wire  do_wr  = ack_q && wb_we_i && wb_sel_i[0];
    wire  do_rd  = ack_q && !wb_we_i;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pend_q <= 1'b0;
            ack_q  <= 1'b0;
        end
        else
        begin
            pend_q <= req && !pend_q && !ack_q;
            ack_q  <= pend_q;
        end
    end

    assign wb_ack_o = ack_q;

    // Setting writes take effect at the acknowledge edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            red_period_q <= REG_RESET;
            green_cur_q  <= REG_RESET;
            blue_cur_q   <= REG_RESET;
            irq_mask_q   <= '0;
        end
        else if (do_wr)
        begin
            if (hit_rp)
                red_period_q <= wb_dat_i[7:0];
            else if (hit_g)
                green_cur_q <= wb_dat_i[7:0];
            else if (hit_b)
                blue_cur_q <= wb_dat_i[7:0];
            else if (hit_mask)
                irq_mask_q <= wb_dat_i[NUM_EV-1:0];
        end
    end

    assign duty.wr_en   = do_wr && hit_duty;
    assign duty.wr_addr = duty_off[AW-1:0];
    assign duty.wr_data = wb_dat_i[7:0];
    assign duty.bus_addr = duty_off[AW-1:0];

    // Read data is captured one cycle after the memory's registered read
    logic [31:0] rd_mux;
    assign rd_mux = hit_rp   ? {24'h0, red_period_q} :
                    hit_g    ? {24'h0, green_cur_q} :
                    hit_b    ? {24'h0, blue_cur_q} :
                    hit_duty ? {24'h0, duty.bus_data} :
                    hit_st   ? {28'h0, irq_status_q} :
                    hit_mask ? {28'h0, irq_mask_q} :
                    hit_live ? {28'h0, split_w, uvlo_w, therm_off_q} :
                               32'h0;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= '0;
        else if (pend_q)
            wb_dat_o <= rd_mux;
    end

    // PWM time base: step length doubles with each period code
    logic [2:0]  period_code;
    logic [15:0] tick_len;
    logic [15:0] div_q;
    logic [7:0]  cnt_q;
    wire  [2:0]  raw_code = red_period_q[PERIOD_SEL_LSB +: 3];

    // Undefined codes above 8 ms are held at the 8 ms setting
    assign period_code = (raw_code > PERIOD_MAX_CODE) ? PERIOD_MAX_CODE : raw_code;
    assign tick_len    = 16'(TICK_CYCLES) << period_code;
    wire   tick        = (div_q >= tick_len - 16'h1);
    wire   period_wrap = tick && (cnt_q == 8'hff);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div_q <= '0;
            cnt_q <= '0;
        end
        else if (tick)
        begin
            div_q <= '0;
            cnt_q <= cnt_q + 8'h1;
        end
        else
        begin
            div_q <= div_q + 16'h1;
        end
    end

    // Scanner walks all duties once per count step through the memory port
    rlp_scan_state_t scan_state_q;
    logic [AW-1:0]   scan_idx_q;
    logic [AW-1:0]   cmp_idx_q;
    logic            cmp_vld_q;
    logic [7:0]      cmp_cnt_q;
    logic [NUM_CH-1:0] act_q;

    assign duty.scan_addr = scan_idx_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            scan_state_q <= RLP_SCAN_IDLE;
            scan_idx_q   <= '0;
            cmp_vld_q    <= 1'b0;
            cmp_idx_q    <= '0;
            cmp_cnt_q    <= '0;
        end
        else
        begin
            cmp_vld_q <= scan_state_q == RLP_SCAN_RUN;
            cmp_idx_q <= scan_idx_q;
            case (scan_state_q)
                RLP_SCAN_IDLE:
                begin
                    if (tick)
                    begin
                        scan_state_q <= RLP_SCAN_RUN;
                        scan_idx_q   <= '0;
                        cmp_cnt_q    <= cnt_q + 8'h1;
                    end
                end
                default:
                begin
                    if (32'(scan_idx_q) == NUM_CH - 1)
                        scan_state_q <= RLP_SCAN_IDLE;
                    else
                        scan_idx_q <= scan_idx_q + 5'h1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            act_q <= '0;
        else if (cmp_vld_q)
            act_q[cmp_idx_q] <= cmp_cnt_q < duty.scan_data;
    end

    // Channel order: red 0..7, green 8..15, blue 16..23
    wire shutdown = uvlo_w || therm_off_q;
    logic [NUM_CH-1:0] out_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            out_q <= '0;
        else
            out_q <= shutdown ? '0 : act_q;
    end

    assign red_channel_out_o   = out_q[7:0];
    assign green_channel_out_o = out_q[15:8];
    assign blue_channel_out_o  = out_q[23:16];

    // Split select: one mask shared by all three groups
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            open_drain_mode_o <= '0;
        else if (split_w == SPLIT_HIGH)
            open_drain_mode_o <= 8'hff;
        else if (split_w == SPLIT_MID)
            open_drain_mode_o <= ~8'((1 << CC_SPLIT_CH) - 1);
        else
            open_drain_mode_o <= 8'h00;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            red_group_current_code_o   <= '0;
            green_group_current_code_o <= '0;
            blue_group_current_code_o  <= '0;
            red_current_pct_o          <= '0;
            green_current_pct_o        <= '0;
            blue_current_pct_o         <= '0;
        end
        else
        begin
            red_group_current_code_o   <= red_period_q[CUR_CODE_LSB +: 3];
            green_group_current_code_o <= green_cur_q[CUR_CODE_LSB +: 3];
            blue_group_current_code_o  <= blue_cur_q[CUR_CODE_LSB +: 3];
            red_current_pct_o   <= rlp_cur_pct(red_period_q[CUR_CODE_LSB +: 3]);
            green_current_pct_o <= rlp_cur_pct(green_cur_q[CUR_CODE_LSB +: 3]);
            blue_current_pct_o  <= rlp_cur_pct(blue_cur_q[CUR_CODE_LSB +: 3]);
        end
    end

    // Sticky events; a new event in the clearing read cycle still sets
    logic [NUM_EV-1:0] ev;
    assign ev[EV_THERM_OFF] = therm_set;
    assign ev[EV_THERM_ON]  = therm_clear;
    assign ev[EV_UVLO]      = uvlo_w && !uvlo_prev_q;
    assign ev[EV_PERIOD]    = period_wrap;
    wire   st_clr           = do_rd && hit_st;
    // Only bits already handed out in the read data are cleared, so an event
    // landing between data capture and acknowledge is not lost
    wire   [NUM_EV-1:0] st_clr_bits = st_clr ? wb_dat_o[NUM_EV-1:0] : '0;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_status_q <= '0;
        else
            irq_status_q <= (irq_status_q & ~st_clr_bits) | ev;
    end

    assign irq_o = |(irq_status_q & irq_mask_q);

endmodule : rlp_pwm_core

// file: tb/rlp_pwm_core_asserts.sv
`timescale 1ns/100ps
module rlp_pwm_core_asserts
    import rlp_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = BASE_TICK_CYCLES
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        irq_o,
    input wire logic        uvlo_i,
    input wire logic        overtemp_i,
    input wire logic [1:0]  output_split_select_i,
    input wire logic [7:0]  red_channel_out_o,
    input wire logic [7:0]  green_channel_out_o,
    input wire logic [7:0]  blue_channel_out_o,
    input wire logic [7:0]  open_drain_mode_o,
    input wire logic [2:0]  red_group_current_code_o,
    input wire logic [6:0]  red_current_pct_o
);
    localparam logic [6:0] PCT [8] = '{7'h14, 7'h1f, 7'h2b, 7'h36, 7'h42, 7'h4d, 7'h58, 7'h64};
    wire logic [23:0] lit = {blue_channel_out_o, green_channel_out_o, red_channel_out_o};
    wire logic [7:0]  od_exp = (output_split_select_i == SPLIT_HIGH) ? 8'hff :
                               (output_split_select_i == SPLIT_MID) ? 8'hc0 : 8'h00;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    ack_bound_a: assert property ($rose(wb_cyc_i && wb_stb_i) |-> ##[1:3] wb_ack_o)
        else $error("request not answered in time");
    reset_clear_a: assert property ($fell(rst_i) |-> lit == 24'h0 && !irq_o && !wb_ack_o)
        else $error("outputs not quiet after reset");
    // Eight samples cover the pin synchroniser plus the output register
    uvlo_dark_a: assert property (uvlo_i [*8] |-> lit == 24'h0)
        else $error("channel active under undervoltage");
    heat_dark_a: assert property (overtemp_i [*8] |-> lit == 24'h0)
        else $error("channel active while overheated");
    split_map_a: assert property ($stable(output_split_select_i) [*8]
        |-> open_drain_mode_o == od_exp)
        else $error("split mode mismatch");
    pct_map_a: assert property ($stable(red_group_current_code_o) [*3]
        |-> red_current_pct_o == PCT[red_group_current_code_o])
        else $error("current percent mismatch");

    cover property (uvlo_i [*8] ##1 !uvlo_i);
    cover property (overtemp_i ##1 !overtemp_i);
    cover property (output_split_select_i == SPLIT_MID && open_drain_mode_o == 8'hc0);
endmodule : rlp_pwm_core_asserts

bind rlp_pwm_core rlp_pwm_core_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .uvlo_i(uvlo_i), .overtemp_i(overtemp_i),
    .output_split_select_i(output_split_select_i), .red_channel_out_o(red_channel_out_o),
    .green_channel_out_o(green_channel_out_o), .blue_channel_out_o(blue_channel_out_o),
    .open_drain_mode_o(open_drain_mode_o), .red_group_current_code_o(red_group_current_code_o),
    .red_current_pct_o(red_current_pct_o)
);

// file: tb/rlp_led_model.sv
`timescale 1ns/100ps
module rlp_led_model (
    input wire logic        clk_i,
    input wire logic        clr_i,
    input wire logic [23:0] led_i
);
    int run_q [24] = '{default: 0};
    int last_q [24] = '{default: 0};
    int hits_q [24] = '{default: 0};

    // Non-blocking so a reader at the same edge sees a settled count
    always @(posedge clk_i)
    begin
        for (int i = 0; i < 24; i++)
        begin
            if (led_i[i])
            begin
                run_q[i] <= run_q[i] + 1;
                hits_q[i] <= hits_q[i] + 1;
            end
            else if (run_q[i] != 0)
            begin
                last_q[i] <= run_q[i];
                run_q[i] <= 0;
            end
            if (clr_i)
                hits_q[i] <= 0;
        end
    end
endmodule : rlp_led_model

// file: tb/rlp_pwm_core_tb.sv
`timescale 1ns/100ps
module rlp_pwm_core_tb
    import rlp_pkg::*;
#(
    // A count step must outlast the 25-cycle duty scan
    parameter int unsigned TICK = 28
);
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [31:0] adr = 32'h0;
    logic [31:0] wdat = 32'h0;
    logic        uvlo = 1'b0;
    logic        ot = 1'b0;
    logic        tres = 1'b1;
    logic [1:0]  split = 2'h0;
    logic        clr = 1'b0;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic        ack;
    logic        irq;
    logic [7:0]  r_out, g_out, b_out, od;
    logic [2:0]  rc, gc, bc;
    logic [6:0]  rp, gp, bp;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          seed = 26;
    int          duty_m [24];
    int          pct_m [8] = '{20, 31, 43, 54, 66, 77, 88, 100};

    always #5 clk_i = ~clk_i;

    rlp_pwm_core #(.TICK_CYCLES(TICK)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(rdat), .wb_ack_o(ack),
        .irq_o(irq), .uvlo_i(uvlo), .overtemp_i(ot), .temp_resume_i(tres),
        .output_split_select_i(split), .red_channel_out_o(r_out), .green_channel_out_o(g_out),
        .blue_channel_out_o(b_out), .open_drain_mode_o(od), .red_group_current_code_o(rc),
        .green_group_current_code_o(gc), .blue_group_current_code_o(bc),
        .red_current_pct_o(rp), .green_current_pct_o(gp), .blue_current_pct_o(bp)
    );
    rlp_led_model led (.clk_i(clk_i), .clr_i(clr), .led_i({b_out, g_out, r_out}));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic results();
        $display("Compared %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= {22'h0, idx, 2'h0};
        wdat <= {24'h0, d};
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        rd = rdat;
        cyc <= 1'b0;
    endtask : wb

    // Counts active cycles of every channel over exactly n clocks
    task automatic window(input int n);
        @(posedge clk_i);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        repeat (n + 1) @(posedge clk_i);
    endtask : window

    initial
    begin
        repeat (95000) @(posedge clk_i);
        fail_count++;
        results();
    end

    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, IDX_RED_PERIOD, 8'h0);
        check("period reg", rd, 0);
        wb(1'b0, IDX_DUTY_BASE + 8'h05, 8'h0);
        check("duty reg", rd, 0);
        wb(1'b1, 8'hff, 8'h5a);
        wb(1'b0, 8'hff, 8'h0);
        check("unmapped", rd, 0);
        for (int c = 0; c < 8; c++)
        begin
            wb(1'b1, IDX_RED_PERIOD, 8'(c));
            wb(1'b1, IDX_GREEN_CUR, 8'(7 - c));
            wb(1'b1, IDX_BLUE_CUR, 8'(c));
            repeat (3) @(posedge clk_i);
            check("red pct", rp, pct_m[c]);
            check("green pct", gp, pct_m[7 - c]);
            check("blue pct", bp, pct_m[c]);
            check("blue code", bc, c);
            check("red code", rc, c);
            check("green code", gc, 7 - c);
        end
        duty_m[0] = 0;
        duty_m[23] = 255;
        for (int i = 1; i < 23; i++)
            duty_m[i] = ($random(seed) & 255) | 1;
        duty_m[1] = 3;
        for (int i = 0; i < 24; i++)
            wb(1'b1, IDX_DUTY_BASE + 8'(i), 8'(duty_m[i]));
        window(512 * TICK);
        for (int i = 1; i < 24; i++)
            check("pulse width", led.last_q[i], duty_m[i] * TICK);
        check("off channel", led.hits_q[0], 0);
        // Switch right after a wrap so step 0 already runs at the new length
        wb(1'b1, IDX_IRQ_MASK, 8'h08);
        for (int p = 0; p < 5; p++)
        begin
            wb(1'b1, IDX_RED_PERIOD, 8'h0);
            wb(1'b0, IDX_IRQ_STATUS, 8'h0);
            do
                @(posedge clk_i);
            while (irq !== 1'b1);
            wb(1'b1, IDX_RED_PERIOD, 8'(p << PERIOD_SEL_LSB));
            repeat ((4 * TICK) << p) @(posedge clk_i);
            check("step length", led.last_q[1], (3 * TICK) << p);
        end
        wb(1'b1, IDX_RED_PERIOD, 8'h0);
        wb(1'b1, IDX_IRQ_MASK, 8'h04);
        wb(1'b0, IDX_IRQ_STATUS, 8'h0);
        uvlo <= 1'b1;
        repeat (8) @(posedge clk_i);
        window(256 * TICK);
        check("uvlo dark", led.hits_q[23], 0);
        check("uvlo irq", irq, 1'b1);
        wb(1'b0, IDX_IRQ_STATUS, 8'h0);
        check("uvlo event", rd[EV_UVLO], 1'b1);
        check("wrap event", rd[EV_PERIOD], 1'b1);
        repeat (2) @(posedge clk_i);
        check("irq masked clear", irq, 1'b0);
        uvlo <= 1'b0;
        repeat (8) @(posedge clk_i);
        window(256 * TICK);
        check("uvlo resume", led.hits_q[23], 255 * TICK);
        ot <= 1'b1;
        tres <= 1'b0;
        repeat (8) @(posedge clk_i);
        window(1024);
        check("hot dark", led.hits_q[23], 0);
        // Cooling but not yet below the resume point keeps the outputs off
        ot <= 1'b0;
        window(1024);
        check("cooling dark", led.hits_q[17], 0);
        tres <= 1'b1;
        repeat (8) @(posedge clk_i);
        window(256 * TICK);
        check("cool resume", led.hits_q[17], duty_m[17] * TICK);
        wb(1'b0, IDX_IRQ_STATUS, 8'h0);
        check("therm off event", rd[EV_THERM_OFF], 1'b1);
        check("therm on event", rd[EV_THERM_ON], 1'b1);
        for (int s = 0; s < 4; s++)
        begin
            split <= 2'(s);
            repeat (8) @(posedge clk_i);
            check("split mode", od, s == 2 ? 8'hff : s == 1 ? 8'hc0 : 8'h00);
        end
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, IDX_DUTY_BASE + 8'h17, 8'h0);
        check("duty after reset", rd, 0);
        window(1024);
        check("dark after reset", led.hits_q[23], 0);
        results();
    end
endmodule : rlp_pwm_core_tb
